// ---- src/lfc_loop_coef.sv ----
// loop-filter coefficient registers, APB slave and coefficient expansion
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module lfc_loop_coef
    import lfc_pkg::*;
#(
    parameter int OW = 64,
    parameter int OF = 40
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output var logic [31:0] prdata,
    output var logic pready,
    output var logic pslverr,
    // effective coefficients to the filter core
    output var logic [OW-1:0] alpha_coef,
    output var logic [OW-1:0] beta_coef,
    output var logic [OW-1:0] gamma_coef,
    output var logic [OW-1:0] delta_coef,
    // feedback divide ratio
    output var logic [LFC_DIVS_W:0] div_int,
    output var logic [LFC_DIVF_W-1:0] div_num,
    output var logic [LFC_DIVF_W-1:0] div_den
);
    // shadow (software written) fields
    logic [LFC_AMANT_W-1:0] sh_amant_ff;
    logic [LFC_ASHIFT_W-1:0] sh_ashift_ff;
    logic [LFC_AFE_W-1:0] sh_afe_ff;
    logic [LFC_ABE_W-1:0] sh_abe_ff;
    logic [LFC_BGMANT_W-1:0] sh_bmant_ff, sh_gmant_ff;
    logic [LFC_EXP_W-1:0] sh_bexp_ff, sh_gexp_ff, sh_dexp_ff;
    logic [LFC_DMANT_W-1:0] sh_dmant_ff;
    logic [LFC_DIVS_W-1:0] sh_divs_ff;
    logic [LFC_DIVF_W-1:0] sh_divu_ff, sh_divv_ff;
    // active fields used by the core
    logic [LFC_AMANT_W-1:0] act_amant_ff;
    logic [LFC_ASHIFT_W-1:0] act_ashift_ff;
    logic [LFC_AFE_W-1:0] act_afe_ff;
    logic [LFC_ABE_W-1:0] act_abe_ff;
    logic [LFC_BGMANT_W-1:0] act_bmant_ff, act_gmant_ff;
    logic [LFC_EXP_W-1:0] act_bexp_ff, act_gexp_ff, act_dexp_ff;
    logic [LFC_DMANT_W-1:0] act_dmant_ff;
    logic [LFC_DIVS_W-1:0] act_divs_ff;
    logic [LFC_DIVF_W-1:0] act_divu_ff, act_divv_ff;
    logic pend_ff;
    logic setup, wr_en, apply, hit;
    logic [31:0] nxt_rdata;
    logic signed [7:0] alpha_rs, beta_rs, gamma_rs, delta_rs;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign apply = wr_en && paddr == LFC_OFS_CTRL && pwdata[LFC_CTRL_APPLY_BIT];

    // read mux and address decode
    always_comb begin
        nxt_rdata = '0;
        hit = 1'b1;
        case (paddr)
            LFC_OFS_ALPHA_MANT: nxt_rdata[LFC_AMANT_W-1:0] = sh_amant_ff;
            LFC_OFS_ALPHA_EXP: begin
                nxt_rdata[LFC_ASHIFT_LSB +: LFC_ASHIFT_W] = sh_ashift_ff;
                nxt_rdata[LFC_AFE_LSB +: LFC_AFE_W] = sh_afe_ff;
                nxt_rdata[LFC_ABE_LSB +: LFC_ABE_W] = sh_abe_ff;
            end
            LFC_OFS_BETA: begin
                nxt_rdata[LFC_BGMANT_W-1:0] = sh_bmant_ff;
                nxt_rdata[LFC_BGEXP_LSB +: LFC_EXP_W] = sh_bexp_ff;
            end
            LFC_OFS_GAMMA: begin
                nxt_rdata[LFC_BGMANT_W-1:0] = sh_gmant_ff;
                nxt_rdata[LFC_BGEXP_LSB +: LFC_EXP_W] = sh_gexp_ff;
            end
            LFC_OFS_DELTA: begin
                nxt_rdata[LFC_DMANT_W-1:0] = sh_dmant_ff;
                nxt_rdata[LFC_DEXP_LSB +: LFC_EXP_W] = sh_dexp_ff;
            end
            LFC_OFS_DIV_INT: nxt_rdata[LFC_DIVS_W-1:0] = sh_divs_ff;
            LFC_OFS_DIV_FRAC: begin
                nxt_rdata[LFC_DIVF_W-1:0] = sh_divu_ff;
                nxt_rdata[LFC_DIVV_LSB +: LFC_DIVF_W] = sh_divv_ff;
            end
            LFC_OFS_CTRL: nxt_rdata = '0;
            LFC_OFS_STATUS: begin
                nxt_rdata[LFC_STAT_PEND_BIT] = pend_ff;
                nxt_rdata[LFC_STAT_ARS_LSB +: 8] = alpha_rs;
            end
            default: hit = 1'b0;
        endcase
    end

    // apb answer: one access cycle, data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup && !hit;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : nxt_rdata;
            end
        end
    end

    // software writes to shadow fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_amant_ff <= LFC_RST_AMANT;
            sh_ashift_ff <= '0;
            sh_afe_ff <= '0;
            sh_abe_ff <= '0;
            sh_bmant_ff <= LFC_RST_BGMANT;
            sh_gmant_ff <= LFC_RST_BGMANT;
            sh_dmant_ff <= LFC_RST_DMANT;
            sh_bexp_ff <= LFC_RST_EXP;
            sh_gexp_ff <= LFC_RST_EXP;
            sh_dexp_ff <= LFC_RST_EXP;
            sh_divs_ff <= LFC_RST_DIVS;
            sh_divu_ff <= LFC_RST_DIVU;
            sh_divv_ff <= LFC_RST_DIVV;
        end else if (wr_en) begin
            case (paddr)
                LFC_OFS_ALPHA_MANT: sh_amant_ff <= pwdata[LFC_AMANT_W-1:0];
                LFC_OFS_ALPHA_EXP: begin
                    sh_ashift_ff <= pwdata[LFC_ASHIFT_LSB +: LFC_ASHIFT_W];
                    sh_afe_ff <= pwdata[LFC_AFE_LSB +: LFC_AFE_W];
                    sh_abe_ff <= pwdata[LFC_ABE_LSB +: LFC_ABE_W];
                end
                LFC_OFS_BETA: begin
                    sh_bmant_ff <= pwdata[LFC_BGMANT_W-1:0];
                    sh_bexp_ff <= pwdata[LFC_BGEXP_LSB +: LFC_EXP_W];
                end
                LFC_OFS_GAMMA: begin
                    sh_gmant_ff <= pwdata[LFC_BGMANT_W-1:0];
                    sh_gexp_ff <= pwdata[LFC_BGEXP_LSB +: LFC_EXP_W];
                end
                LFC_OFS_DELTA: begin
                    sh_dmant_ff <= pwdata[LFC_DMANT_W-1:0];
                    sh_dexp_ff <= pwdata[LFC_DEXP_LSB +: LFC_EXP_W];
                end
                LFC_OFS_DIV_INT: sh_divs_ff <= pwdata[LFC_DIVS_W-1:0];
                LFC_OFS_DIV_FRAC: begin
                    sh_divu_ff <= pwdata[LFC_DIVF_W-1:0];
                    sh_divv_ff <= pwdata[LFC_DIVV_LSB +: LFC_DIVF_W];
                end
                default: ;
            endcase
        end
    end

    // apply copies all shadows at once so the core never sees a half-written set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_amant_ff <= LFC_RST_AMANT;
            act_ashift_ff <= '0;
            act_afe_ff <= '0;
            act_abe_ff <= '0;
            act_bmant_ff <= LFC_RST_BGMANT;
            act_gmant_ff <= LFC_RST_BGMANT;
            act_dmant_ff <= LFC_RST_DMANT;
            act_bexp_ff <= LFC_RST_EXP;
            act_gexp_ff <= LFC_RST_EXP;
            act_dexp_ff <= LFC_RST_EXP;
            act_divs_ff <= LFC_RST_DIVS;
            act_divu_ff <= LFC_RST_DIVU;
            act_divv_ff <= LFC_RST_DIVV;
        end else if (apply) begin
            act_amant_ff <= sh_amant_ff;
            act_ashift_ff <= sh_ashift_ff;
            act_afe_ff <= sh_afe_ff;
            act_abe_ff <= sh_abe_ff;
            act_bmant_ff <= sh_bmant_ff;
            act_gmant_ff <= sh_gmant_ff;
            act_dmant_ff <= sh_dmant_ff;
            act_bexp_ff <= sh_bexp_ff;
            act_gexp_ff <= sh_gexp_ff;
            act_dexp_ff <= sh_dexp_ff;
            act_divs_ff <= sh_divs_ff;
            act_divu_ff <= sh_divu_ff;
            act_divv_ff <= sh_divv_ff;
        end
    end

    // pending: set by a shadow write, cleared by apply
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_ff <= 1'b0;
        end else if (wr_en && paddr < LFC_OFS_CTRL) begin
            pend_ff <= 1'b1;
        end else if (apply) begin
            pend_ff <= 1'b0;
        end
    end

    assign alpha_rs = LFC_ALPHA_BIAS + 8'(act_ashift_ff) - 8'(act_afe_ff) - 8'(act_abe_ff);
    assign beta_rs = LFC_BG_BIAS + 8'(act_bexp_ff);
    assign gamma_rs = LFC_BG_BIAS + 8'(act_gexp_ff);
    assign delta_rs = LFC_DELTA_BIAS + 8'(act_dexp_ff);

    lfc_coef_expand #(.MW(LFC_AMANT_W), .OW(OW), .OF(OF), .NEG(1'b0)) u_alpha (
        .pclk(pclk), .presetn(presetn), .mant(act_amant_ff), .rshift(alpha_rs),
        .coef(alpha_coef));
    lfc_coef_expand #(.MW(LFC_BGMANT_W), .OW(OW), .OF(OF), .NEG(1'b1)) u_beta (
        .pclk(pclk), .presetn(presetn), .mant(act_bmant_ff), .rshift(beta_rs),
        .coef(beta_coef));
    lfc_coef_expand #(.MW(LFC_BGMANT_W), .OW(OW), .OF(OF), .NEG(1'b1)) u_gamma (
        .pclk(pclk), .presetn(presetn), .mant(act_gmant_ff), .rshift(gamma_rs),
        .coef(gamma_coef));
    lfc_coef_expand #(.MW(LFC_DMANT_W), .OW(OW), .OF(OF), .NEG(1'b0)) u_delta (
        .pclk(pclk), .presetn(presetn), .mant(act_dmant_ff), .rshift(delta_rs),
        .coef(delta_coef));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_int <= '0;
            div_num <= '0;
            div_den <= '0;
        end else begin
            div_int <= {1'b0, act_divs_ff} + (LFC_DIVS_W+1)'(1);
            div_num <= act_divu_ff;
            div_den <= act_divv_ff;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_apb_ready;
        setup |=> pready ##1 !pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb answer not one cycle");

    // release edge skipped, outputs still hold reset zeros there
    property p_alpha_unity;
        ($past(presetn) && act_ashift_ff == 0 && act_afe_ff == 0 && act_abe_ff == 0)
            |=> alpha_coef == (OW'($past(act_amant_ff)) << (OF - 16));
    endproperty
    a_alpha_unity: assert property (p_alpha_unity) else $error("alpha scale wrong");

    property p_alpha_gain;
        (act_ashift_ff == 2 && act_afe_ff == 7 && act_abe_ff == 1)
            |=> alpha_coef == (OW'($past(act_amant_ff)) << (OF - 10));
    endproperty
    a_alpha_gain: assert property (p_alpha_gain) else $error("alpha gain wrong");

    property p_beta_mag;
        act_bexp_ff == 3 |=> beta_coef == OW'(-((OW'($past(act_bmant_ff)) << OF) >> 20));
    endproperty
    a_beta_mag: assert property (p_beta_mag) else $error("beta magnitude wrong");

    property p_gamma_neg;
        ($past(presetn) && act_gmant_ff != 0 && act_gexp_ff == 0) |=> gamma_coef[OW-1];
    endproperty
    a_gamma_neg: assert property (p_gamma_neg) else $error("gamma not negative");

    property p_delta_val;
        ($past(presetn) && act_dexp_ff == 0)
            |=> delta_coef == (OW'($past(act_dmant_ff)) << (OF - 15));
    endproperty
    a_delta_val: assert property (p_delta_val) else $error("delta scale wrong");

    property p_div_plus1;
        apply ##2 1'b1 |-> div_int == {1'b0, $past(sh_divs_ff, 2)} + 31'h00000001;
    endproperty
    a_div_plus1: assert property (p_div_plus1) else $error("divide ratio wrong");

    property p_shift_halves;
        (act_dexp_ff == 1 && $past(act_dexp_ff) == 0 && $stable(act_dmant_ff))
            |=> delta_coef == ($past(delta_coef) >> 1);
    endproperty
    a_shift_halves: assert property (p_shift_halves) else $error("exp step not a shift");

    c_apply: cover property (apply ##2 pend_ff == 1'b0);
    c_alpha_gain: cover property (act_afe_ff == 7 && act_abe_ff != 0);
    c_slverr: cover property (pslverr);
endmodule // lfc_loop_coef
`default_nettype wire

// ---- src/lfc_pkg.sv ----
// loop-filter coefficient block: register map, field layout and reset values
package lfc_pkg;
    // register byte offsets
    localparam logic [7:0] LFC_OFS_ALPHA_MANT = 8'h00;
    localparam logic [7:0] LFC_OFS_ALPHA_EXP = 8'h04;
    localparam logic [7:0] LFC_OFS_BETA = 8'h08;
    localparam logic [7:0] LFC_OFS_GAMMA = 8'h0C;
    localparam logic [7:0] LFC_OFS_DELTA = 8'h10;
    localparam logic [7:0] LFC_OFS_DIV_INT = 8'h14;
    localparam logic [7:0] LFC_OFS_DIV_FRAC = 8'h18;
    localparam logic [7:0] LFC_OFS_CTRL = 8'h1C;
    localparam logic [7:0] LFC_OFS_STATUS = 8'h20;
    // field widths
    localparam int LFC_AMANT_W = 16;
    localparam int LFC_ASHIFT_W = 6;
    localparam int LFC_AFE_W = 3;
    localparam int LFC_ABE_W = 4;
    localparam int LFC_BGMANT_W = 17;
    localparam int LFC_DMANT_W = 15;
    localparam int LFC_EXP_W = 5;
    localparam int LFC_DIVS_W = 30;
    localparam int LFC_DIVF_W = 10;
    // field positions
    localparam int LFC_ASHIFT_LSB = 0;
    localparam int LFC_AFE_LSB = 8;
    localparam int LFC_ABE_LSB = 16;
    localparam int LFC_BGEXP_LSB = 24;
    localparam int LFC_DEXP_LSB = 16;
    localparam int LFC_DIVV_LSB = 16;
    localparam int LFC_CTRL_APPLY_BIT = 0;
    localparam int LFC_STAT_PEND_BIT = 0;
    localparam int LFC_STAT_ARS_LSB = 8;
    // exponent biases
    localparam logic signed [7:0] LFC_ALPHA_BIAS = 8'sh10;
    localparam logic signed [7:0] LFC_BG_BIAS = 8'sh11;
    localparam logic signed [7:0] LFC_DELTA_BIAS = 8'sh0F;
    // reset values
    localparam logic [15:0] LFC_RST_AMANT = 16'h0001;
    localparam logic [16:0] LFC_RST_BGMANT = 17'h00001;
    localparam logic [14:0] LFC_RST_DMANT = 15'h0001;
    localparam logic [4:0] LFC_RST_EXP = 5'h00;
    localparam logic [29:0] LFC_RST_DIVS = 30'h00000000;
    localparam logic [9:0] LFC_RST_DIVU = 10'h000;
    localparam logic [9:0] LFC_RST_DIVV = 10'h001;
endpackage

// ---- src/lfc_coef_expand.sv ----
// shift-based expansion of one mantissa/exponent coefficient into fixed point
`timescale 1ns/10ps
`default_nettype none
module lfc_coef_expand #(
    parameter int MW = 16,
    parameter int OW = 64,
    parameter int OF = 40,
    parameter bit NEG = 1'b0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // coefficient fields
    input wire logic [MW-1:0] mant,
    input wire logic signed [7:0] rshift,
    // expanded value, OF fractional bits, two's complement
    output var logic [OW-1:0] coef
);
    logic [OW-1:0] base;
    logic [OW-1:0] mag;
    logic [7:0] lshift;

    always_comb begin
        base = OW'(mant) << OF;
        lshift = 8'(-rshift);
        // bits below 2^-OF are truncated, small coefficients lose precision
        if (rshift < 0) begin
            mag = base << lshift;
        end else begin
            mag = base >> rshift;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef <= '0;
        end else if (NEG) begin
            coef <= ~mag + OW'(1);
        end else begin
            coef <= mag;
        end
    end
endmodule // lfc_coef_expand
`default_nettype wire

// ---- bench/lfc_loop_coef_bench.sv ----
// self-checking bench for the loop-filter coefficient block
`timescale 1ns/10ps
`default_nettype none
module lfc_loop_coef_bench import lfc_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [63:0] alpha_coef, beta_coef, gamma_coef, delta_coef;
    logic [LFC_DIVS_W:0] div_int;
    logic [LFC_DIVF_W-1:0] div_num, div_den;
    int err_count, check_count;
    // register model: shadow fields and the copy taken at apply
    logic [31:0] regs [0:6];
    logic [31:0] act [0:6];
    logic [31:0] rst_val [0:6] = '{32'h00000001, 32'h00000000, 32'h00000001, 32'h00000001,
        32'h00000001, 32'h00000000, 32'h00010000};
    logic [31:0] msk [0:6] = '{32'h0000FFFF, 32'h000F073F, 32'h1F01FFFF, 32'h1F01FFFF,
        32'h001F7FFF, 32'h3FFFFFFF, 32'h03FF03FF};

    lfc_loop_coef #(.OW(64), .OF(40)) i_lfc_loop_coef (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alpha_coef(alpha_coef), .beta_coef(beta_coef),
        .gamma_coef(gamma_coef), .delta_coef(delta_coef), .div_int(div_int),
        .div_num(div_num), .div_den(div_den)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk_coef(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t coefficient %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t register %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer, idle cycle first so no signal is driven twice per step
    // answer taken at the rising edge that samples pready high
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            $display("MISMATCH t=%0t no ready", $time);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr_reg(input int i, input logic [31:0] wd);
        xfer(8'(i * 4), 1'b1, wd);
        regs[i] = wd & msk[i];
    endtask

    task automatic rd_all();
        for (int i = 0; i < 7; i++) begin
            xfer(8'(i * 4), 1'b0, 32'h00000000);
            chk_reg(rd, regs[i]);
            chk_reg({31'h0, err}, 32'h00000000);
        end
    endtask

    // outputs land one edge after the apply write
    task automatic apply();
        xfer(LFC_OFS_CTRL, 1'b1, 32'h00000001);
        act = regs;
        repeat (2) @(negedge pclk);
    endtask

    function automatic logic [63:0] shl(input logic [63:0] m, input int e);
        return (e >= 0) ? (m << e) : (m >> (-e));
    endfunction

    // expected outputs from the applied fields, 40 fraction bits
    task automatic chk_outs();
        int e;
        e = 24 - int'(act[1][5:0]) + int'(act[1][10:8]) + int'(act[1][19:16]);
        chk_coef(alpha_coef, shl(64'(act[0][15:0]), e));
        chk_coef(beta_coef, -shl(64'(act[2][16:0]), 23 - int'(act[2][28:24])));
        chk_coef(gamma_coef, -shl(64'(act[3][16:0]), 23 - int'(act[3][28:24])));
        chk_coef(delta_coef, shl(64'(act[4][14:0]), 25 - int'(act[4][20:16])));
        chk_coef(64'(div_int), 64'(act[5][29:0]) + 64'h1);
        chk_coef({44'h0, div_den, div_num}, {44'h0, act[6][25:16], act[6][9:0]});
    endtask

    task automatic chk_status(input logic pend);
        logic [7:0] ns;
        ns = 8'(16 + int'(act[1][5:0]) - int'(act[1][10:8]) - int'(act[1][19:16]));
        xfer(LFC_OFS_STATUS, 1'b0, 32'h00000000);
        chk_reg(rd, {16'h0, ns, 7'h0, pend});
    endtask

    initial begin
        #3000000;
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        presetn = 1'b0;
        err_count = 0;
        check_count = 0;
        regs = rst_val;
        act = rst_val;
        void'($urandom(47));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // outputs valid from the first edge after release
        repeat (2) @(negedge pclk);
        chk_outs();
        rd_all();
        chk_status(1'b0);
        // worked example; outputs must not move before apply
        // quantised alpha, beta, gamma and delta fields
        wr_reg(0, 32'h0000D0A8);
        wr_reg(1, 32'h00000006);
        wr_reg(2, 32'h0D01250B);
        wr_reg(3, 32'h0D013ABB);
        wr_reg(4, 32'h0008420A);
        chk_outs();
        chk_status(1'b1);
        apply();
        chk_outs();
        chk_coef(alpha_coef, 64'h00000003_42A00000);
        chk_status(1'b0);
        // gain eight split seven plus one
        wr_reg(1, 32'h00010702);
        wr_reg(2, 32'h03000005);
        apply();
        chk_outs();
        // net left shift, then a delta exponent step of one
        wr_reg(1, 32'h000F0700);
        wr_reg(4, 32'h0000420A);
        apply();
        chk_outs();
        wr_reg(4, 32'h0001420A);
        apply();
        chk_outs();
        // all-ones, all-zero, then random fields
        for (int k = 0; k < 24; k++) begin
            for (int i = 0; i < 7; i++) begin
                d = $urandom();
                if (k < 2) d = (k == 0) ? 32'hFFFFFFFF : 32'h00000000;
                wr_reg(i, d);
            end
            apply();
            chk_outs();
            if (k < 4) rd_all();
        end
        // unmapped writes are refused, status writes complete without error and are ignored, neither has side effects
        xfer(8'h24, 1'b1, 32'hFFFFFFFF);
        chk_reg({31'h0, err}, 32'h00000001);
        xfer(8'h24, 1'b0, 32'h00000000);
        chk_reg(rd, 32'h00000000);
        chk_reg({31'h0, err}, 32'h00000001);
        xfer(LFC_OFS_STATUS, 1'b1, 32'hFFFFFFFF);
        rd_all();
        chk_status(1'b0);
        // second reset in mid-run restores the reset fields
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        regs = rst_val;
        act = rst_val;
        repeat (2) @(negedge pclk);
        chk_outs();
        rd_all();
        end_sim();
    end
endmodule // lfc_loop_coef_bench
`default_nettype wire
